// >>> rtsr_host_model.sv
// Host model issuing single-byte register accesses
`timescale 1ns/1ps
module rtsr_host_model (
  // Clock
  input wire logic i_clk,
  // Register port
  output rtsr_pkg::rtsr_req_t o_req,
  input wire logic [7:0] i_rdata
);
  logic [7:0] got;
  initial o_req = '0;
  // One write, skipped for the synth and gain test addresses; idle cycles show inverted lines
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    if (a == rtsr_pkg::ADDR_SYNTH_TEST || a == rtsr_pkg::ADDR_GAIN_TEST) return;
    @(posedge i_clk) o_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge i_clk) o_req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
  endtask : wr
  // One read; data is taken once settled
  task automatic rd(input logic [5:0] a);
    @(posedge i_clk) o_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge i_clk) o_req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'hFF};
    @(posedge i_clk) got = i_rdata;
  endtask : rd
endmodule : rtsr_host_model

// >>> rtsr_monitor.sv
// Port checker for the radio test and status register bank
`timescale 1ns/1ps
module rtsr_monitor #(
  parameter logic [7:0] PART_ID = 8'hA5
) (
  // Clock, reset and requests
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire rtsr_pkg::rtsr_req_t i_req,
  input wire logic i_sleep,
  input wire logic i_converter_hold_select,
  input wire logic i_radio_idle,
  input wire rtsr_pkg::rtsr_demod_t i_demod,
  // Outputs under watch
  input wire logic [7:0] o_rdata,
  input wire logic [7:0] o_synth_test,
  input wire logic [7:0] o_gain_test,
  input wire logic [7:0] o_trim_b_analog,
  input wire logic [7:0] o_trim_a_analog,
  input wire logic o_temp_sensor_en,
  input wire logic o_osc_core_select_cal_enable
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  // A read of one address
  sequence s_rd(logic [5:0] a);
    i_req.rd && i_req.addr == a;
  endsequence
  // Checks on sleep, trims and status reads
  a_sleep_clear: assert property (i_sleep ##1 i_sleep |-> o_synth_test == 8'h59 && o_gain_test == 8'h3F)
    else $error("test registers kept during sleep");
  a_wake_force: assert property ($fell(i_sleep) |-> ##[0:1]
    o_trim_b_analog == (i_converter_hold_select ? 8'h81 : 8'h88)
    && o_trim_a_analog == (i_converter_hold_select ? 8'h35 : 8'h31))
    else $error("analog trim copies wrong after wake");
  a_temp_idle: assert property (o_temp_sensor_en |-> $past(i_radio_idle))
    else $error("temperature sensor on outside idle");
  a_osc_write: assert property (i_req.wr && i_req.addr == 6'h2E && !i_sleep && !$past(i_sleep)
    |=> o_osc_core_select_cal_enable == $past(i_req.wdata[1]))
    else $error("oscillator selection enable wrong");
  a_offset_zero: assert property (i_req.rd && i_req.addr == 6'h32 && !i_demod.fsk_mode
    && !$past(i_demod.fsk_mode) |=> o_rdata == 8'h00)
    else $error("offset nonzero without frequency keying");
  a_part_read: assert property (s_rd(6'h30) |=> o_rdata == PART_ID)
    else $error("part id read wrong");
  a_crc_set: assert property (i_demod.crc_done && i_demod.crc_match ##1 s_rd(6'h33) |=> o_rdata[7])
    else $error("checksum flag not set");
  a_crc_clear: assert property (i_demod.rx_enter && !i_demod.crc_done ##1 s_rd(6'h33) |=> !o_rdata[7])
    else $error("checksum flag not cleared");
endmodule : rtsr_monitor

bind rtsr_regs rtsr_monitor #(.PART_ID(PART_ID)) u_mon (.i_clk, .i_resetn, .i_req, .i_sleep,
  .i_converter_hold_select, .i_radio_idle, .i_demod, .o_rdata, .o_synth_test, .o_gain_test,
  .o_trim_b_analog, .o_trim_a_analog, .o_temp_sensor_en, .o_osc_core_select_cal_enable);

// >>> rtsr_pkg.sv
// Package for the radio test and status register bank
package rtsr_pkg;
  localparam logic [5:0] ADDR_SYNTH_TEST = 6'h29;
  localparam logic [5:0] ADDR_PROD_TEST = 6'h2A;
  localparam logic [5:0] ADDR_GAIN_TEST = 6'h2B;
  localparam logic [5:0] ADDR_TRIM_B = 6'h2C;
  localparam logic [5:0] ADDR_TRIM_A = 6'h2D;
  localparam logic [5:0] ADDR_TRIM_C = 6'h2E;
  localparam logic [5:0] ADDR_PART_ID = 6'h30;
  localparam logic [5:0] ADDR_REV_ID = 6'h31;
  localparam logic [5:0] ADDR_OFFSET_EST = 6'h32;
  localparam logic [5:0] ADDR_LINK_QUAL = 6'h33;
  localparam logic [5:0] ADDR_SIGNAL_LVL = 6'h34;
  localparam logic [5:0] ADDR_STATUS_LO = 6'h30;
  localparam logic [5:0] ADDR_STATUS_HI = 6'h34;
  localparam logic [7:0] RST_SYNTH_TEST = 8'h59;
  localparam logic [7:0] RST_PROD_TEST = 8'h7F;
  localparam logic [7:0] RST_GAIN_TEST = 8'h3F;
  localparam logic [7:0] RST_TRIM_B = 8'h88;
  localparam logic [7:0] RST_TRIM_A = 8'h31;
  localparam logic [7:0] RST_TRIM_C = 8'h0B;
  localparam logic [7:0] WAKE_TRIM_B_HOLD = 8'h81;
  localparam logic [7:0] WAKE_TRIM_A_HOLD = 8'h35;
  localparam logic [7:0] PROD_TEST_TEMP_ON = 8'hBF;
  localparam int OSC_SEL_BIT = 1;
  localparam int CRC_OK_BIT = 7;
  localparam logic [6:0] LQI_SYMBOLS = 7'h40;
  // Register access request from the serial port decoder
  typedef struct packed {
    logic wr;
    logic rd;
    logic [5:0] addr;
    logic [7:0] wdata;
  } rtsr_req_t;
  // Demodulator measurement inputs
  typedef struct packed {
    logic fsk_mode;
    logic [7:0] offset;
    logic sym_valid;
    logic [3:0] sym_quality;
    logic sync_found;
    logic crc_done;
    logic crc_match;
    logic rx_enter;
    logic [7:0] level;
  } rtsr_demod_t;
endpackage : rtsr_pkg

// >>> rtsr_regs.sv
// Radio test, trim and status register bank
// How it works
// - Test and trim registers return to reset values while in sleep.
// - Production test value 0xBF enables temperature sensor while idle.
// - On wake, internal trim B copy is 0x88 or 0x81 by converter hold.
// - Trim B reads 0x88 after wake whatever the converter hold setting.
// - On wake, internal trim A copy is 0x31 or 0x35 by converter hold.
// - Trim A reads 0x31 after wake regardless of converter hold.
// - Oscillator core selection calibration stage runs only when trim C bit 1 set.
// - Carrier offset is eight-bit two's complement, crystal over 2^14 units.
// - Carrier offset reads zero for amplitude or on-off keying.
// - Link quality bit 7 shows checksum match, cleared on receive entry unless a checksum result arrives in the same cycle.
// - Link quality estimate spans 64 symbols after sync word.
// - Signal level is a read-only eight-bit status value.
`timescale 1ns/1ps
module rtsr_regs #(
  parameter logic [7:0] PART_ID = 8'hA5, // Arbitrary value
  parameter logic [7:0] REV_ID = 8'h5A // Arbitrary value
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_resetn,
  // Register access
  input wire rtsr_pkg::rtsr_req_t i_req,
  output logic [7:0] o_rdata,
  // Power state and converter hold setting
  input wire logic i_sleep,
  input wire logic i_converter_hold_select,
  input wire logic i_radio_idle,
  // Demodulator measurements
  input wire rtsr_pkg::rtsr_demod_t i_demod,
  // Analog controls
  output logic [7:0] o_synth_test,
  output logic [7:0] o_gain_test,
  output logic [7:0] o_trim_b_analog,
  output logic [7:0] o_trim_a_analog,
  output logic o_temp_sensor_en,
  output logic o_osc_core_select_cal_enable
);
  // Register map, host side
  // 0x29 synth test control, reset 0x59, factory use only
  // 0x2A production test control, reset 0x7F, 0xBF opens the temperature sensor
  // 0x2B gain loop test control, reset 0x3F, factory use only
  // 0x2C analog trim B, reads 0x88 after wake
  // 0x2D analog trim A, reads 0x31 after wake
  // 0x2E analog trim C, bit 1 enables oscillator core selection in calibration
  // 0x30 part identity, arbitrary parameter value
  // 0x31 revision identity, arbitrary parameter value
  // 0x32 carrier offset estimate, two's complement
  // 0x33 link quality: bit 7 checksum match, bits 6:0 estimate
  // 0x34 received signal level
  // Test and trim registers lose host values in sleep
  // Analog trim copies may differ from what the host reads back
  // Writes are refused in sleep and in the first awake cycle
  // Unmapped reads return zero
  // Link quality window length is a package constant
  // Checksum flag: a same-cycle result beats a receive restart
  // Host visible test and trim registers
  logic [7:0] synth_test_reg, synth_test_next;
  logic [7:0] prod_test_reg, prod_test_next;
  logic [7:0] gain_test_reg, gain_test_next;
  logic [7:0] trim_b_reg, trim_b_next;
  logic [7:0] trim_a_reg, trim_a_next;
  logic [7:0] trim_c_reg, trim_c_next;

  // Analog copies and sleep history
  logic [7:0] trim_b_an_reg, trim_b_an_next;
  logic [7:0] trim_a_an_reg, trim_a_an_next;
  logic sleep_reg, sleep_next;

  // Write strobes and wake pulse
  logic wake_pulse;
  logic wr_open;
  logic wr_synth;
  logic wr_prod;
  logic wr_gain;
  logic wr_trim_b;
  logic wr_trim_a;
  logic wr_trim_c;

  // Demodulator status
  logic [7:0] offset_reg, offset_next;
  logic [6:0] lqi_reg, lqi_next;
  logic crc_ok_reg, crc_ok_next;
  logic [6:0] sym_cnt_reg, sym_cnt_next;
  logic [10:0] lqi_acc_reg, lqi_acc_next;
  logic lqi_run_reg, lqi_run_next;
  logic [7:0] level_reg, level_next;
  logic lqi_last;

  // Read path and sensor enable
  logic [7:0] rdata_reg, rdata_next;
  logic temp_en_reg, temp_en_next;

  // Write strobes, one per writable register
  always_comb begin
    wake_pulse = !i_sleep && sleep_reg;
    wr_open = i_req.wr && !i_sleep && !sleep_reg; // Refused in sleep and wake cycle
    wr_synth = 1'b0;
    wr_prod = 1'b0;
    wr_gain = 1'b0;
    wr_trim_b = 1'b0;
    wr_trim_a = 1'b0;
    wr_trim_c = 1'b0;
    // Decode only while writes are open
    if (wr_open) begin
      if (i_req.addr == rtsr_pkg::ADDR_SYNTH_TEST) begin
        wr_synth = 1'b1;
      end else if (i_req.addr == rtsr_pkg::ADDR_PROD_TEST) begin
        wr_prod = 1'b1;
      end else if (i_req.addr == rtsr_pkg::ADDR_GAIN_TEST) begin
        wr_gain = 1'b1;
      end else if (i_req.addr == rtsr_pkg::ADDR_TRIM_B) begin
        wr_trim_b = 1'b1;
      end else if (i_req.addr == rtsr_pkg::ADDR_TRIM_A) begin
        wr_trim_a = 1'b1;
      end else if (i_req.addr == rtsr_pkg::ADDR_TRIM_C) begin
        wr_trim_c = 1'b1;
      end
    end
  end

  // Test and trim registers: host writes, cleared in sleep, forced on wake
  always_comb begin
    synth_test_next = synth_test_reg;
    prod_test_next = prod_test_reg;
    gain_test_next = gain_test_reg;
    trim_b_next = trim_b_reg;
    trim_a_next = trim_a_reg;
    trim_c_next = trim_c_reg;
    trim_b_an_next = trim_b_an_reg;
    trim_a_an_next = trim_a_an_reg;
    sleep_next = i_sleep;
    // Sleep wipes the host visible copies
    if (i_sleep) begin
      synth_test_next = rtsr_pkg::RST_SYNTH_TEST;
      prod_test_next = rtsr_pkg::RST_PROD_TEST;
      gain_test_next = rtsr_pkg::RST_GAIN_TEST;
      trim_b_next = rtsr_pkg::RST_TRIM_B;
      trim_a_next = rtsr_pkg::RST_TRIM_A;
      trim_c_next = rtsr_pkg::RST_TRIM_C;
    end else if (wake_pulse) begin
      // Wake-up: analog copies take the converter-hold dependent value
      trim_b_an_next = i_converter_hold_select ? rtsr_pkg::WAKE_TRIM_B_HOLD : rtsr_pkg::RST_TRIM_B;
      trim_a_an_next = i_converter_hold_select ? rtsr_pkg::WAKE_TRIM_A_HOLD : rtsr_pkg::RST_TRIM_A;
    end else begin
      // Each strobe loads its own register; status addresses have none
      if (wr_synth) begin
        synth_test_next = i_req.wdata;
      end
      if (wr_prod) begin
        prod_test_next = i_req.wdata;
      end
      if (wr_gain) begin
        gain_test_next = i_req.wdata;
      end
      if (wr_trim_b) begin
        trim_b_next = i_req.wdata;
        trim_b_an_next = i_req.wdata;
      end
      if (wr_trim_a) begin
        trim_a_next = i_req.wdata;
        trim_a_an_next = i_req.wdata;
      end
      if (wr_trim_c) begin
        trim_c_next = i_req.wdata;
      end
    end
    // Sensor only while idle with the enabling code loaded
    temp_en_next = i_radio_idle && (prod_test_reg == rtsr_pkg::PROD_TEST_TEMP_ON);
  end

  // Register the test, trim and wake state
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      synth_test_reg <= rtsr_pkg::RST_SYNTH_TEST;
      prod_test_reg <= rtsr_pkg::RST_PROD_TEST;
      gain_test_reg <= rtsr_pkg::RST_GAIN_TEST;
      trim_b_reg <= rtsr_pkg::RST_TRIM_B;
      trim_a_reg <= rtsr_pkg::RST_TRIM_A;
      trim_c_reg <= rtsr_pkg::RST_TRIM_C;
      trim_b_an_reg <= rtsr_pkg::RST_TRIM_B;
      trim_a_an_reg <= rtsr_pkg::RST_TRIM_A;
      sleep_reg <= 1'b0;
      temp_en_reg <= 1'b0;
    end else begin
      synth_test_reg <= synth_test_next;
      prod_test_reg <= prod_test_next;
      gain_test_reg <= gain_test_next;
      trim_b_reg <= trim_b_next;
      trim_a_reg <= trim_a_next;
      trim_c_reg <= trim_c_next;
      trim_b_an_reg <= trim_b_an_next;
      trim_a_an_reg <= trim_a_an_next;
      sleep_reg <= sleep_next;
      temp_en_reg <= temp_en_next;
    end
  end

  // Demodulator status capture
  always_comb begin
    lqi_last = lqi_run_reg && i_demod.sym_valid && (sym_cnt_reg == rtsr_pkg::LQI_SYMBOLS - 7'h01);
    offset_next = i_demod.fsk_mode ? i_demod.offset : 8'h00;
    level_next = i_demod.level;
    lqi_next = lqi_reg;
    sym_cnt_next = sym_cnt_reg;
    lqi_acc_next = lqi_acc_reg;
    lqi_run_next = lqi_run_reg;
    crc_ok_next = crc_ok_reg;
    // Match result set wins over a same-cycle receive restart
    if (i_demod.crc_done) begin
      crc_ok_next = i_demod.crc_match;
    end else if (i_demod.rx_enter) begin
      crc_ok_next = 1'b0;
    end
    // Sum symbol quality over the window after sync; the estimate is the sum over 8
    if (i_demod.sync_found) begin
      lqi_run_next = 1'b1;
      sym_cnt_next = 7'h00;
      lqi_acc_next = 11'h000;
    end else if (lqi_run_reg && i_demod.sym_valid) begin
      lqi_acc_next = lqi_acc_reg + {7'h00, i_demod.sym_quality};
      sym_cnt_next = sym_cnt_reg + 7'h01;
      if (lqi_last) begin
        lqi_run_next = 1'b0;
        lqi_next = lqi_acc_next[9:3];
      end
    end
  end

  // Register the demodulator status
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      offset_reg <= 8'h00;
      level_reg <= 8'h00;
      lqi_reg <= 7'h00;
      sym_cnt_reg <= 7'h00;
      lqi_acc_reg <= 11'h000;
      lqi_run_reg <= 1'b0;
      crc_ok_reg <= 1'b0;
    end else begin
      offset_reg <= offset_next;
      level_reg <= level_next;
      lqi_reg <= lqi_next;
      sym_cnt_reg <= sym_cnt_next;
      lqi_acc_reg <= lqi_acc_next;
      lqi_run_reg <= lqi_run_next;
      crc_ok_reg <= crc_ok_next;
    end
  end

  // Read data mux, registered
  always_comb begin
    rdata_next = rdata_reg;
    if (i_req.rd) begin
      if (i_req.addr == rtsr_pkg::ADDR_SYNTH_TEST) begin
        rdata_next = synth_test_reg;
      end else if (i_req.addr == rtsr_pkg::ADDR_PROD_TEST) begin
        rdata_next = prod_test_reg;
      end else if (i_req.addr == rtsr_pkg::ADDR_GAIN_TEST) begin
        rdata_next = gain_test_reg;
      end else if (i_req.addr == rtsr_pkg::ADDR_TRIM_B) begin
        rdata_next = trim_b_reg;
      end else if (i_req.addr == rtsr_pkg::ADDR_TRIM_A) begin
        rdata_next = trim_a_reg;
      end else if (i_req.addr == rtsr_pkg::ADDR_TRIM_C) begin
        rdata_next = trim_c_reg;
        // Status registers, read only
      end else if (i_req.addr == rtsr_pkg::ADDR_PART_ID) begin
        rdata_next = PART_ID;
      end else if (i_req.addr == rtsr_pkg::ADDR_REV_ID) begin
        rdata_next = REV_ID;
      end else if (i_req.addr == rtsr_pkg::ADDR_OFFSET_EST) begin
        rdata_next = offset_reg;
      end else if (i_req.addr == rtsr_pkg::ADDR_LINK_QUAL) begin
        rdata_next = {crc_ok_reg, lqi_reg};
      end else if (i_req.addr == rtsr_pkg::ADDR_SIGNAL_LVL) begin
        rdata_next = level_reg;
      end else begin
        rdata_next = 8'h00;
      end
    end
  end

  // Register the read data
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rdata_reg <= 8'h00;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  // Outputs straight from flip-flops
  assign o_rdata = rdata_reg;
  assign o_synth_test = synth_test_reg;
  assign o_gain_test = gain_test_reg;
  assign o_trim_b_analog = trim_b_an_reg;
  assign o_trim_a_analog = trim_a_an_reg;
  assign o_temp_sensor_en = temp_en_reg;
  assign o_osc_core_select_cal_enable = trim_c_reg[rtsr_pkg::OSC_SEL_BIT];
endmodule : rtsr_regs

// >>> tb.sv
// Self-checking bench for the radio test and status register bank
`timescale 1ns/1ps
module tb;
  logic i_clk = 1'b0;
  logic i_resetn = 1'b0;
  logic i_sleep = 1'b0;
  logic i_converter_hold_select = 1'b0;
  logic i_radio_idle = 1'b0;
  rtsr_pkg::rtsr_demod_t i_demod = '0;
  rtsr_pkg::rtsr_req_t i_req;
  logic [7:0] o_rdata, o_synth_test, o_gain_test, o_trim_b_analog, o_trim_a_analog;
  logic o_temp_sensor_en, o_osc_core_select_cal_enable;
  logic [5:0] ra [9] = '{6'h29, 6'h2A, 6'h2B, 6'h2C, 6'h2D, 6'h2E, 6'h30, 6'h31, 6'h3F};
  logic [7:0] rv [9] = '{8'h59, 8'h7F, 8'h3F, 8'h88, 8'h31, 8'h0B, 8'hA5, 8'h5A, 8'h00};
  int failures = 0;
  int comparisons = 0;
  int cycles = 0;
  // Clock and run limit
  always #5 i_clk = ~i_clk;
  always @(posedge i_clk) if (++cycles == 4000) begin
    failures++;
    give_verdict();
  end
  rtsr_host_model host (.i_clk(i_clk), .o_req(i_req), .i_rdata(o_rdata));
  rtsr_regs DUT (.i_clk, .i_resetn, .i_req, .o_rdata, .i_sleep, .i_converter_hold_select, .i_radio_idle,
    .i_demod, .o_synth_test, .o_gain_test, .o_trim_b_analog, .o_trim_a_analog, .o_temp_sensor_en,
    .o_osc_core_select_cal_enable);
  // Compare helpers
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    comparisons++;
    if (g !== e) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic rdc(input logic [5:0] a, input logic [7:0] e);
    host.rd(a);
    chk(host.got, e);
  endtask : rdc
  task automatic step(input int n);
    repeat (n) @(posedge i_clk);
  endtask : step
  task automatic give_verdict;
    $display("Comparisons %0d, failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : give_verdict
  // Test sequence
  initial begin
    step(3);
    i_resetn <= 1'b1;
    for (int i = 0; i < 9; i++) rdc(ra[i], rv[i]);
    $display("Test reset values done");
    host.wr(6'h2A, 8'hBF);
    i_radio_idle <= 1'b1;
    step(2);
    chk({7'h00, o_temp_sensor_en}, 8'h01);
    i_radio_idle <= 1'b0;
    step(2);
    chk({7'h00, o_temp_sensor_en}, 8'h00);
    host.wr(6'h2A, 8'h7F);
    i_radio_idle <= 1'b1;
    step(2);
    chk({7'h00, o_temp_sensor_en}, 8'h00);
    for (int b = 0; b < 2; b++) begin
      host.wr(6'h2E, {6'h02, b[0], 1'b1});
      step(1);
      chk({7'h00, o_osc_core_select_cal_enable}, {7'h00, b[0]});
    end
    $display("Test temperature and oscillator done");
    i_demod.level <= 8'hC3;
    i_demod.offset <= 8'hA3;
    host.wr(6'h30, 8'hFF);
    host.wr(6'h34, 8'h00);
    rdc(6'h30, 8'hA5);
    rdc(6'h34, 8'hC3);
    rdc(6'h32, 8'h00);
    i_demod.fsk_mode <= 1'b1;
    step(2);
    rdc(6'h32, 8'hA3);
    $display("Test status reads done");
    i_demod.sym_quality <= 4'hF;
    i_demod.sync_found <= 1'b1;
    step(1);
    i_demod.sync_found <= 1'b0;
    i_demod.sym_valid <= 1'b1;
    step(64);
    i_demod.sym_valid <= 1'b0;
    i_demod.crc_done <= 1'b1;
    i_demod.crc_match <= 1'b1;
    step(1);
    i_demod.crc_done <= 1'b0;
    step(1);
    rdc(6'h33, 8'hF8);
    i_demod.rx_enter <= 1'b1;
    step(1);
    i_demod.rx_enter <= 1'b0;
    host.rd(6'h33);
    chk({host.got[7], 7'h00}, 8'h00);
    $display("Test link quality done");
    for (int h = 0; h < 2; h++) begin
      host.wr(6'h2C, 8'h12);
      host.wr(6'h2D, 8'h34);
      i_converter_hold_select <= h[0];
      i_sleep <= 1'b1;
      step(3);
      host.wr(6'h2A, 8'h55);
      i_sleep <= 1'b0;
      step(2);
      chk(o_trim_b_analog, h[0] ? 8'h81 : 8'h88);
      chk(o_trim_a_analog, h[0] ? 8'h35 : 8'h31);
      rdc(6'h2C, 8'h88);
      rdc(6'h2D, 8'h31);
      rdc(6'h2A, 8'h7F);
    end
    $display("Test sleep and wake done");
    give_verdict();
  end
endmodule : tb
